/* asc_pkg.sv */
`default_nettype none
package asc_pkg;
   // register offsets as the serial interface addresses them
   localparam logic [7:0] ANGLE_OFFSET = 8'h00;
   localparam logic [7:0] ERR_OFFSET = 8'h04;
   localparam logic [7:0] ERR2_OFFSET = 8'h05;
   localparam logic [7:0] CTRL_OFFSET = 8'h08;
   // operation_control field positions
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int CTRL_MODE_BIT = 2;
   localparam int CTRL_START_BIT = 4;
   // second error register field positions
   localparam int ERR2_MANCH_BIT = 6;
   localparam int ERR2_LOGIC_BIT = 4;
   localparam int ERR2_TRANSDUCER_BIT = 3;
   // nv self-test selection bits
   localparam int SEL_LOGIC_BIT = 0;
   localparam int SEL_TRANSDUCER_BIT = 1;
   // reset values
   localparam logic [6:0] ERR_RESET = 7'h01;
   localparam logic [6:0] ERR2_RESET = 7'h00;
   localparam logic [11:0] ANGLE_RESET = 12'h000;
   // timing
   localparam int CLK_HZ = 10_000_000;
   localparam int LOGIC_TEST_MS = 10;
   localparam int TRANSDUCER_TEST_MS = 40;
   localparam int LOGIC_TEST_CYCLES = LOGIC_TEST_MS * (CLK_HZ / 1000);
   localparam int TRANSDUCER_TEST_CYCLES = TRANSDUCER_TEST_MS * (CLK_HZ / 1000);
   localparam int REFRESH_CYCLES = 100;
   typedef enum logic [1:0] {ASC_IDLE, ASC_LOGIC, ASC_TRANSDUCER} asc_test_state_t;
endpackage : asc_pkg
`default_nettype wire

/* asc_selftest_seq.sv */
`timescale 1ns/10ps
`default_nettype none
module asc_selftest_seq #(
   parameter int unsigned LOGIC_CYCLES = asc_pkg::LOGIC_TEST_CYCLES,
   parameter int unsigned TRANSDUCER_CYCLES = asc_pkg::TRANSDUCER_TEST_CYCLES
)(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [1:0] select,
   input wire logic logicTestBad,
   input wire logic transducerTestBad,
   output logic busy_q,
   output logic logicFail_q,
   output logic transducerFail_q
);
   localparam int CW = $clog2(TRANSDUCER_CYCLES + LOGIC_CYCLES + 1);
   asc_pkg::asc_test_state_t state_q, state_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic busy_d, logicFail_d, transducerFail_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 1'b1;
      logicFail_d = 1'b0;
      transducerFail_d = 1'b0;
      case (state_q)
         asc_pkg::ASC_IDLE: begin
            cnt_d = '0;
            // a start with nothing selected runs no test
            if (start && select[asc_pkg::SEL_LOGIC_BIT]) begin
               state_d = asc_pkg::ASC_LOGIC;
            end else if (start && select[asc_pkg::SEL_TRANSDUCER_BIT]) begin
               state_d = asc_pkg::ASC_TRANSDUCER;
            end
         end
         asc_pkg::ASC_LOGIC: begin
            if (cnt_q == CW'(LOGIC_CYCLES - 1)) begin
               cnt_d = '0;
               logicFail_d = logicTestBad;
               state_d = select[asc_pkg::SEL_TRANSDUCER_BIT] ? asc_pkg::ASC_TRANSDUCER : asc_pkg::ASC_IDLE;
            end
         end
         asc_pkg::ASC_TRANSDUCER: begin
            if (cnt_q == CW'(TRANSDUCER_CYCLES - 1)) begin
               cnt_d = '0;
               transducerFail_d = transducerTestBad;
               state_d = asc_pkg::ASC_IDLE;
            end
         end
         default: begin
            state_d = asc_pkg::ASC_IDLE;
            cnt_d = '0;
         end
      endcase
      busy_d = (state_d != asc_pkg::ASC_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_q <= asc_pkg::ASC_IDLE;
         cnt_q <= '0;
         busy_q <= 1'b0;
         logicFail_q <= 1'b0;
         transducerFail_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         logicFail_q <= logicFail_d;
         transducerFail_q <= transducerFail_d;
      end
   end
endmodule : asc_selftest_seq
`default_nettype wire

/* asc_angle_path.sv */
`timescale 1ns/10ps
`default_nettype none
module asc_angle_path #(
   parameter int unsigned REFRESH_CYCLES = asc_pkg::REFRESH_CYCLES
)(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic suspend,
   input wire logic [11:0] rawAngle,
   input wire logic [11:0] refAngle,
   output logic [11:0] angle_q,
   output logic angleStrobe_q,
   output logic angleValid_q
);
   localparam int RW = $clog2(REFRESH_CYCLES + 1);
   logic [RW-1:0] tick_q, tick_d;
   logic [11:0] angle_d;
   logic angleStrobe_d, angleValid_d, tickNow;

   always_comb begin
      tickNow = (tick_q == RW'(REFRESH_CYCLES - 1));
      tick_d = tickNow ? '0 : tick_q + 1'b1;
      angle_d = angle_q;
      angleStrobe_d = 1'b0;
      angleValid_d = angleValid_q;
      if (suspend) begin
         // no readings while a test owns the front end
         angleValid_d = 1'b0;
      end else if (tickNow) begin
         angle_d = rawAngle - refAngle;
         angleStrobe_d = 1'b1;
         angleValid_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tick_q <= '0;
         angle_q <= asc_pkg::ANGLE_RESET;
         angleStrobe_q <= 1'b0;
         angleValid_q <= 1'b0;
      end else begin
         tick_q <= tick_d;
         angle_q <= angle_d;
         angleStrobe_q <= angleStrobe_d;
         angleValid_q <= angleValid_d;
      end
   end
endmodule : asc_angle_path
`default_nettype wire

/* asc_ctrl_diag_regs.sv */
// Functional notes
// - logic self-test failure sets second-error bit 4
// - transducer self-test failure sets second-error bit 3
// - execute fields start at once, read zero
// - start bit launches nv-selected self-tests
// - logic test about 10 ms, no angles
// - transducer test about 40 ms, no angles
// - clear bit clears error register flags
// - mode bit loaded from nv at power-up
// - host may override mode bit anytime
// - power cycle restores nv mode, drops override
// - averaging enabled only while mode bit one
// - reported angle is raw minus reference
// - angle samples at fixed refresh interval
// - error flags sticky until clear or reset
// - unmasked error drives serial error indication
`timescale 1ns/10ps
`default_nettype none
module asc_ctrl_diag_regs #(
   parameter int unsigned LOGIC_TEST_CYCLES = asc_pkg::LOGIC_TEST_CYCLES,
   parameter int unsigned TRANSDUCER_TEST_CYCLES = asc_pkg::TRANSDUCER_TEST_CYCLES,
   parameter int unsigned REFRESH_CYCLES = asc_pkg::REFRESH_CYCLES
)(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [12:0] regRdData_q,
   input wire logic [6:0] errEvent,
   input wire logic manchesterErr,
   input wire logic [6:0] nvErrMask,
   input wire logic [6:0] nvErr2Mask,
   input wire logic [1:0] nvSelftestSelect,
   input wire logic nvSamplingSpeedDefault,
   input wire logic logicTestBad,
   input wire logic transducerTestBad,
   input wire logic [11:0] rawAngle,
   input wire logic [11:0] nvRefAngle,
   output logic [11:0] angleOut_q,
   output logic angleStrobe_q,
   output logic angleValid_q,
   output logic selftestBusy_q,
   output logic averagingEnable_q,
   output logic serialErrFlag_q
);
   logic ctrlWr, selftestStart, errorFlagsClear;
   logic logicFailPulse, transducerFailPulse, angleSuspend;
   logic ctrlMode_q, ctrlMode_d;
   logic averagingEnable_d;
   logic [6:0] err_q, err_d, err2_q, err2_d, err2Set;
   logic serialErrFlag_d;
   logic [12:0] regRdData_d;

   // execute fields act in the write cycle itself and keep no storage
   always_comb begin
      ctrlWr = regWrEn && (regAddr == asc_pkg::CTRL_OFFSET);
      selftestStart = ctrlWr && regWrData[asc_pkg::CTRL_START_BIT];
      errorFlagsClear = ctrlWr && regWrData[asc_pkg::CTRL_CLEAR_BIT];
   end

   asc_selftest_seq #(
      .LOGIC_CYCLES(LOGIC_TEST_CYCLES),
      .TRANSDUCER_CYCLES(TRANSDUCER_TEST_CYCLES)
   ) u_seq (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .start(selftestStart),
      .select(nvSelftestSelect),
      .logicTestBad(logicTestBad),
      .transducerTestBad(transducerTestBad),
      .busy_q(selftestBusy_q),
      .logicFail_q(logicFailPulse),
      .transducerFail_q(transducerFailPulse)
   );

   // a failing test's result cycle still suspends angles so its flag lands first
   always_comb begin
      angleSuspend = selftestBusy_q || logicFailPulse || transducerFailPulse;
   end

   asc_angle_path #(
      .REFRESH_CYCLES(REFRESH_CYCLES)
   ) u_angle (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .suspend(angleSuspend),
      .rawAngle(rawAngle),
      .refAngle(nvRefAngle),
      .angle_q(angleOut_q),
      .angleStrobe_q(angleStrobe_q),
      .angleValid_q(angleValid_q)
   );

   // mode bit: every control write loads it from the mode field; other fields are ignored
   always_comb begin
      ctrlMode_d = ctrlMode_q;
      if (ctrlWr) begin
         ctrlMode_d = regWrData[asc_pkg::CTRL_MODE_BIT];
      end
      averagingEnable_d = ctrlMode_d;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         // reset is power-on here, so any run-time override is lost
         ctrlMode_q <= nvSamplingSpeedDefault;
         averagingEnable_q <= nvSamplingSpeedDefault;
      end else begin
         ctrlMode_q <= ctrlMode_d;
         averagingEnable_q <= averagingEnable_d;
      end
   end

   // error flags: sticky, a new event in the clear cycle wins
   always_comb begin
      err2Set = '0;
      err2Set[asc_pkg::ERR2_MANCH_BIT] = manchesterErr;
      err2Set[asc_pkg::ERR2_LOGIC_BIT] = logicFailPulse;
      err2Set[asc_pkg::ERR2_TRANSDUCER_BIT] = transducerFailPulse;
      if (errorFlagsClear) begin
         err_d = errEvent;
         err2_d = err2Set;
      end else begin
         err_d = err_q | errEvent;
         err2_d = err2_q | err2Set;
      end
      serialErrFlag_d = |(err_d & ~nvErrMask) || |(err2_d & ~nvErr2Mask);
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         err_q <= asc_pkg::ERR_RESET;
         err2_q <= asc_pkg::ERR2_RESET;
         serialErrFlag_q <= 1'b0;
      end else begin
         err_q <= err_d;
         err2_q <= err2_d;
         serialErrFlag_q <= serialErrFlag_d;
      end
   end

   // read data; unmapped offsets answer zero
   always_comb begin
      regRdData_d = regRdData_q;
      if (regRdEn) begin
         case (regAddr)
            asc_pkg::ANGLE_OFFSET: regRdData_d = {angleOut_q, 1'b0};
            asc_pkg::ERR_OFFSET: regRdData_d = {6'h00, err_q};
            asc_pkg::ERR2_OFFSET: regRdData_d = {6'h00, err2_q};
            // execute and reserved fields always read zero
            asc_pkg::CTRL_OFFSET: begin
               regRdData_d = '0;
               regRdData_d[asc_pkg::CTRL_MODE_BIT] = ctrlMode_q;
            end
            default: regRdData_d = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         regRdData_q <= '0;
      end else begin
         regRdData_q <= regRdData_d;
      end
   end

   // helper state for the checks below
   logic [1:0] selAtStart_q;
   logic [31:0] busyLen_q;
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         selAtStart_q <= 2'h0;
         busyLen_q <= '0;
      end else begin
         if (selftestStart && !selftestBusy_q) begin
            selAtStart_q <= nvSelftestSelect;
         end
         busyLen_q <= selftestBusy_q ? busyLen_q + 32'h1 : 32'h0;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_logic_fail_flag;
      logicFailPulse |=> err2_q[asc_pkg::ERR2_LOGIC_BIT];
   endproperty
   a_logic_fail_flag: assert property (p_logic_fail_flag) else $error("logic fail flag not set");

   property p_transducer_fail_flag;
      transducerFailPulse |=> err2_q[asc_pkg::ERR2_TRANSDUCER_BIT];
   endproperty
   a_transducer_fail_flag: assert property (p_transducer_fail_flag) else $error("transducer flag not set");

   property p_no_spurious_fail;
      !logicFailPulse && !err2_q[asc_pkg::ERR2_LOGIC_BIT] |=> !err2_q[asc_pkg::ERR2_LOGIC_BIT];
   endproperty
   a_no_spurious_fail: assert property (p_no_spurious_fail) else $error("logic flag set without failure");

   property p_ctrl_reads_zero;
      regRdEn && regAddr == asc_pkg::CTRL_OFFSET
         |=> regRdData_q[4:3] == 2'b00 && regRdData_q[1:0] == 2'b00 && regRdData_q[12:5] == 8'h00;
   endproperty
   a_ctrl_reads_zero: assert property (p_ctrl_reads_zero) else $error("control field read nonzero");

   property p_start_launches;
      selftestStart && !selftestBusy_q && nvSelftestSelect != 2'b00 |=> selftestBusy_q;
   endproperty
   a_start_launches: assert property (p_start_launches) else $error("start did not launch test");

   property p_zero_no_launch;
      !selftestBusy_q && !selftestStart |=> !selftestBusy_q;
   endproperty
   a_zero_no_launch: assert property (p_zero_no_launch) else $error("test began without start");

   property p_logic_length;
      $fell(selftestBusy_q) && selAtStart_q == 2'b01 |-> $past(busyLen_q) == 32'(LOGIC_TEST_CYCLES - 1);
   endproperty
   a_logic_length: assert property (p_logic_length) else $error("logic test length wrong");

   property p_transducer_length;
      $fell(selftestBusy_q) && selAtStart_q == 2'b10
         |-> $past(busyLen_q) == 32'(TRANSDUCER_TEST_CYCLES - 1);
   endproperty
   a_transducer_length: assert property (p_transducer_length) else $error("transducer test length wrong");

   property p_no_angle_in_test;
      selftestBusy_q |=> !angleStrobe_q && !angleValid_q;
   endproperty
   a_no_angle_in_test: assert property (p_no_angle_in_test) else $error("angle during self-test");

   property p_clear_err;
      errorFlagsClear |=> err_q == $past(errEvent);
   endproperty
   a_clear_err: assert property (p_clear_err) else $error("clear left stale flags");

   property p_sticky_err;
      !errorFlagsClear |=> (err_q & $past(err_q)) == $past(err_q);
   endproperty
   a_sticky_err: assert property (p_sticky_err) else $error("error flag dropped");

   property p_mode_write;
      ctrlWr |=> ctrlMode_q == $past(regWrData[asc_pkg::CTRL_MODE_BIT]) ##1 averagingEnable_q == ctrlMode_q;
   endproperty
   a_mode_write: assert property (p_mode_write) else $error("mode write not applied");

   property p_avg_follows_mode;
      !ctrlWr |=> averagingEnable_q == ctrlMode_q;
   endproperty
   a_avg_follows_mode: assert property (p_avg_follows_mode) else $error("averaging differs from mode");

   property p_err_indication;
      // rst_n in the antecedent: the release edge still shows the reset values of the flags
      rst_n && |(err_q & ~nvErrMask) && !errorFlagsClear && $stable(nvErrMask) |=> serialErrFlag_q;
   endproperty
   a_err_indication: assert property (p_err_indication) else $error("error indication missing");

   property p_flag_before_resume;
      transducerFailPulse |=> err2_q[asc_pkg::ERR2_TRANSDUCER_BIT] && !angleStrobe_q;
   endproperty
   a_flag_before_resume: assert property (p_flag_before_resume) else $error("angle before flag update");

   property p_no_false_transducer;
      !transducerFailPulse && !err2_q[asc_pkg::ERR2_TRANSDUCER_BIT] |=> !err2_q[asc_pkg::ERR2_TRANSDUCER_BIT];
   endproperty
   a_no_false_transducer: assert property (p_no_false_transducer) else $error("false transducer flag");

   property p_sticky_err2;
      !errorFlagsClear |=> (err2_q & $past(err2_q)) == $past(err2_q);
   endproperty
   a_sticky_err2: assert property (p_sticky_err2) else $error("second error flag dropped");

   property p_empty_select;
      selftestStart && !selftestBusy_q && nvSelftestSelect == 2'b00 |=> !selftestBusy_q;
   endproperty
   a_empty_select: assert property (p_empty_select) else $error("test ran with nothing selected");

   property p_mode_hold;
      !ctrlWr |=> ctrlMode_q == $past(ctrlMode_q);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode bit changed without write");

   property p_err_read;
      regRdEn && regAddr == asc_pkg::ERR_OFFSET |=> regRdData_q == {6'h00, $past(err_q)};
   endproperty
   a_err_read: assert property (p_err_read) else $error("error register read wrong");

   property p_err_quiet;
      errEvent == 7'h00 && !manchesterErr && !logicFailPulse && !transducerFailPulse
         && (err_q & ~nvErrMask) == 7'h00 && (err2_q & ~nvErr2Mask) == 7'h00 |=> !serialErrFlag_q;
   endproperty
   a_err_quiet: assert property (p_err_quiet) else $error("error indication without flag");

   property p_angle_value;
      angleStrobe_q |-> angleOut_q == 12'($past(rawAngle) - $past(nvRefAngle));
   endproperty
   a_angle_value: assert property (p_angle_value) else $error("angle not raw minus reference");

   property p_strobe_single;
      angleStrobe_q |=> !angleStrobe_q;
   endproperty
   a_strobe_single: assert property (p_strobe_single) else $error("angle strobe longer than one cycle");
endmodule : asc_ctrl_diag_regs
`default_nettype wire

/* asc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module asc_host_model (
   input wire logic core_clk,
   output logic regWrEn,
   output logic regRdEn,
   output logic [7:0] regAddr,
   output logic [7:0] regWrData,
   input wire logic [12:0] regRdData_q
);
   initial begin
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
   end
   // strobe, address and data held through the taking edge; released lines show the inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrEn <= 1'b0;
      regAddr <= ~a;
      regWrData <= ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [12:0] d);
      @(posedge core_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRdEn <= 1'b0;
      regAddr <= ~a;
      #1;
      d = regRdData_q;
   endtask : rd
endmodule : asc_host_model
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int LC = 20;
   localparam int TC = 40;
   localparam int RC = 8;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic regWrEn, regRdEn;
   logic [7:0] regAddr, regWrData;
   logic [12:0] regRdData_q, rdVal;
   logic [6:0] errEvent = 7'h00, nvErrMask = 7'h00, nvErr2Mask = 7'h00;
   logic manchesterErr = 1'b0, nvSamplingSpeedDefault = 1'b0;
   logic [1:0] nvSelftestSelect = 2'b00;
   logic logicTestBad = 1'b0, transducerTestBad = 1'b0;
   logic [11:0] rawAngle = 12'h000, nvRefAngle = 12'h000, angleOut_q;
   logic angleStrobe_q, angleValid_q, selftestBusy_q, averagingEnable_q, serialErrFlag_q;
   integer seed = 32'h7df6;
   int errorCnt = 0;
   int nTests = 0;
   always #50 core_clk = ~core_clk;
   asc_ctrl_diag_regs #(.LOGIC_TEST_CYCLES(LC), .TRANSDUCER_TEST_CYCLES(TC), .REFRESH_CYCLES(RC))
   asc_ctrl_diag_regs_i (.core_clk(core_clk), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q), .errEvent(errEvent),
      .manchesterErr(manchesterErr), .nvErrMask(nvErrMask), .nvErr2Mask(nvErr2Mask),
      .nvSelftestSelect(nvSelftestSelect), .nvSamplingSpeedDefault(nvSamplingSpeedDefault),
      .logicTestBad(logicTestBad), .transducerTestBad(transducerTestBad), .rawAngle(rawAngle),
      .nvRefAngle(nvRefAngle), .angleOut_q(angleOut_q), .angleStrobe_q(angleStrobe_q),
      .angleValid_q(angleValid_q), .selftestBusy_q(selftestBusy_q),
      .averagingEnable_q(averagingEnable_q), .serialErrFlag_q(serialErrFlag_q));
   asc_host_model host_i (.core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData_q(regRdData_q));
   task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
      nTests++;
      if (seen !== exp) begin
         errorCnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   function automatic logic [11:0] expAngle(input logic [11:0] raw, input logic [11:0] rf);
      // the reported angle wraps modulo one turn
      return raw - rf;
   endfunction : expAngle
   task automatic finish_test();
      if (errorCnt == 0 && nTests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic doReset(input logic nv);
      @(posedge core_clk);
      rst_n <= 1'b0;
      nvSamplingSpeedDefault <= nv;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      #1;
   endtask : doReset
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask : settle
   task automatic runTest(input logic [1:0] sel, input logic lb, input logic tb2, input int cyc,
                          input logic [12:0] e2);
      int k;
      logic bad;
      k = 0;
      bad = 1'b0;
      @(posedge core_clk);
      nvSelftestSelect <= sel;
      logicTestBad <= lb;
      transducerTestBad <= tb2;
      host_i.wr(asc_pkg::CTRL_OFFSET, 8'h10);
      #1;
      // bounded: a stuck busy runs out the count and shows as a wrong length
      // the angle path sees busy one edge late, so each busy cycle is judged after its edge
      while (selftestBusy_q === 1'b1 && k < 1000) begin
         k++;
         @(posedge core_clk);
         #1;
         if (angleStrobe_q !== 1'b0 || angleValid_q !== 1'b0) bad = 1'b1;
      end
      chk("busyCycles", 13'(k), 13'(cyc));
      chk("quietWhileBusy", {12'h000, bad}, 13'h0000);
      host_i.rd(asc_pkg::ERR2_OFFSET, rdVal);
      chk("err2", rdVal, e2);
   endtask : runTest
   task automatic waitStrobe(output int k);
      k = 0;
      do begin
         @(posedge core_clk);
         #1;
         k++;
      end while (angleStrobe_q !== 1'b1 && k < 1000);
   endtask : waitStrobe
   task automatic angleCheck(input logic [11:0] raw, input logic [11:0] rf);
      int k;
      @(posedge core_clk);
      rawAngle <= raw;
      nvRefAngle <= rf;
      waitStrobe(k);
      waitStrobe(k);
      waitStrobe(k);
      chk("angle", {1'b0, angleOut_q}, {1'b0, expAngle(raw, rf)});
      chk("refreshGap", 13'(k), 13'(RC));
      chk("valid", {12'h000, angleValid_q}, 13'h0001);
   endtask : angleCheck
   initial begin
      doReset(1'b1);
      chk("avgAtPowerUp", {12'h000, averagingEnable_q}, 13'h0001);
      host_i.rd(asc_pkg::CTRL_OFFSET, rdVal);
      chk("ctrlAtPowerUp", rdVal, 13'h0004);
      host_i.rd(asc_pkg::ERR_OFFSET, rdVal);
      chk("errAtPowerUp", rdVal, 13'h0001);
      chk("errFlag", {12'h000, serialErrFlag_q}, 13'h0001);
      @(posedge core_clk);
      // a selection is armed so a misdecoded start bit would show as busy
      nvSelftestSelect <= 2'b11;
      nvErrMask <= 7'h01;
      settle();
      chk("maskedFlag", {12'h000, serialErrFlag_q}, 13'h0000);
      host_i.rd(asc_pkg::ERR_OFFSET, rdVal);
      chk("maskedStillSet", rdVal, 13'h0001);
      host_i.wr(asc_pkg::CTRL_OFFSET, 8'hea);
      #1;
      chk("noTestOnZero", {12'h000, selftestBusy_q}, 13'h0000);
      host_i.rd(asc_pkg::CTRL_OFFSET, rdVal);
      chk("ctrlReserved", rdVal, 13'h0000);
      chk("avgOff", {12'h000, averagingEnable_q}, 13'h0000);
      host_i.rd(asc_pkg::ERR_OFFSET, rdVal);
      chk("noClearOnZero", rdVal, 13'h0001);
      host_i.wr(asc_pkg::CTRL_OFFSET, 8'h04);
      host_i.rd(asc_pkg::CTRL_OFFSET, rdVal);
      chk("modeOverride", rdVal, 13'h0004);
      chk("avgOn", {12'h000, averagingEnable_q}, 13'h0001);
      @(posedge core_clk);
      errEvent <= 7'h10;
      manchesterErr <= 1'b1;
      nvErrMask <= 7'h00;
      @(posedge core_clk);
      errEvent <= 7'h00;
      manchesterErr <= 1'b0;
      settle();
      host_i.rd(asc_pkg::ERR_OFFSET, rdVal);
      chk("errSticky", rdVal, 13'h0011);
      host_i.rd(asc_pkg::ERR2_OFFSET, rdVal);
      chk("err2Sticky", rdVal, 13'h0040);
      chk("errFlagSet", {12'h000, serialErrFlag_q}, 13'h0001);
      host_i.wr(asc_pkg::CTRL_OFFSET, 8'h05);
      host_i.rd(asc_pkg::ERR_OFFSET, rdVal);
      chk("errCleared", rdVal, 13'h0000);
      host_i.rd(asc_pkg::CTRL_OFFSET, rdVal);
      chk("clearReadsZero", rdVal, 13'h0004);
      chk("errFlagClear", {12'h000, serialErrFlag_q}, 13'h0000);
      runTest(2'b01, 1'b1, 1'b0, LC, 13'h0010);
      runTest(2'b10, 1'b0, 1'b1, TC, 13'h0018);
      chk("err2Flag", {12'h000, serialErrFlag_q}, 13'h0001);
      @(posedge core_clk);
      nvErr2Mask <= 7'h18;
      settle();
      chk("err2Masked", {12'h000, serialErrFlag_q}, 13'h0000);
      @(posedge core_clk);
      nvErr2Mask <= 7'h00;
      host_i.wr(asc_pkg::CTRL_OFFSET, 8'h01);
      runTest(2'b11, 1'b0, 1'b0, LC + TC, 13'h0000);
      runTest(2'b00, 1'b1, 1'b1, 0, 13'h0000);
      angleCheck(12'h000, 12'h001);
      angleCheck(12'hfff, 12'h000);
      repeat (4) angleCheck(12'($random(seed)), 12'($random(seed)));
      host_i.wr(asc_pkg::CTRL_OFFSET, 8'h04);
      doReset(1'b0);
      chk("overrideDropped", {12'h000, averagingEnable_q}, 13'h0000);
      host_i.rd(asc_pkg::CTRL_OFFSET, rdVal);
      chk("ctrlAfterCycle", rdVal, 13'h0000);
      finish_test();
   end
endmodule : tb
`default_nettype wire
